// >>> src/uio_bank.sv
/*
 * upper i/o register bank of a 4-bit controller: a/d flag and control,
 * output port with buzzer and divided-clock, bidirectional port, 16-bit
 * up-counter, timer reset, load mode, lcd, tone and a/d clock selects,
 * plus an interrupt status/enable/clear set, all behind an axi4-lite slave.
 * assumes: one 50 mhz clock; frequency sources and a/d done come from logic
 * on the same clock; the bidirectional pin level arrives asynchronously.
 */
module uio_bank #(
	parameter int ADDR_W = 12,
	parameter bit DIVIDED_CLOCK_OUT_USE = 1'b1,
	parameter bit BUZZER_USE = 1'b1
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_adc_done,
	input wire logic i_count_tick,
	input wire logic [3:0] i_divided_clock_out_src,
	input wire logic i_buzz_2k,
	input wire logic i_buzz_4k,
	input wire logic [3:0] i_bidir_in,
	output logic [3:0] o_bidir_out,
	output logic [3:0] o_bidir_oe_n,
	output logic [3:0] o_out_pins,
	output logic o_adc_go,
	output logic o_adc_channel,
	output logic o_adc_fast_clk,
	output logic o_timer_clear,
	output logic o_heavy_load,
	output logic o_lcd_static,
	output logic o_irq
);
	// refuse address widths too narrow to hold the 10-bit register index above the two byte bits
	if (ADDR_W < 12) begin : g_addr_chk
		$error("uio_bank: ADDR_W must be at least 12");
	end

	typedef struct packed {
		logic aw_full;
		logic [ADDR_W-1:0] aw_addr;
		logic w_full;
		logic [3:0] w_nib;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [3:0] rdata;
		logic [1:0] rresp;
		logic adc_irq_flag;
		logic adc_go;
		logic adc_channel_pick;
		logic [3:0] out_data;
		logic [3:0] bidir_latch;
		logic [15:0] upcount;
		logic timer_clear_cmd;
		logic heavy_load_select;
		logic lcd_static_dynamic;
		logic port_direction_bit;
		logic buzzer_tone_select;
		logic [1:0] freq_out_sel;
		logic adc_clock_pick;
		logic [uio_pkg::NUM_EV-1:0] irq_stat;
		logic [uio_pkg::NUM_EV-1:0] irq_en;
		logic [3:0] pins;
	} uio_state_t;

	uio_state_t st_reg;
	uio_state_t st_next;
	logic [3:0] pin_level;
	logic [9:0] w_idx;
	logic [9:0] r_idx;
	logic [3:0] rd_nib;
	logic rd_hit;
	logic rd_take;
	logic [uio_pkg::NUM_EV-1:0] ev;
	logic [3:0] port_view;
	logic tone;

	// ---------------------------------------------------------------
	// pin synchroniser
	// ---------------------------------------------------------------
	uio_sync #(
		.WIDTH(4)
	) u_bidir_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_async(i_bidir_in),
		.o_level(pin_level)
	);

	// ---------------------------------------------------------------
	// address decode and read mux
	// ---------------------------------------------------------------
	assign w_idx = st_reg.aw_addr[uio_pkg::ADDR_LSB +: 10];
	assign r_idx = i_araddr[uio_pkg::ADDR_LSB +: 10];
	assign rd_take = i_arvalid && !st_reg.rvalid;
	// port reads the pin while listening, the latch while driving
	assign port_view = st_reg.port_direction_bit ? st_reg.bidir_latch : pin_level;

	// unused bit positions are tied to zero in every branch
	always_comb begin
		rd_nib = uio_pkg::NIB_RESET;
		rd_hit = 1'b1;
		if (r_idx == uio_pkg::IDX_ADC_FLAG) begin
			rd_nib[uio_pkg::BIT_D0] = st_reg.adc_irq_flag;
		end else if (r_idx == uio_pkg::IDX_ADC_CTRL) begin
			rd_nib[uio_pkg::BIT_D0] = st_reg.adc_go;
			rd_nib[uio_pkg::BIT_D3] = st_reg.adc_channel_pick;
		end else if (r_idx == uio_pkg::IDX_OUT_PORT) begin
			rd_nib = st_reg.out_data;
		end else if (r_idx == uio_pkg::IDX_BIDIR_DATA) begin
			rd_nib = port_view;
		end else if (r_idx == uio_pkg::IDX_CNT_LOW) begin
			rd_nib = st_reg.upcount[3:0];
		end else if (r_idx == uio_pkg::IDX_CNT_MIDLOW) begin
			rd_nib = st_reg.upcount[7:4];
		end else if (r_idx == uio_pkg::IDX_CNT_MIDHIGH) begin
			rd_nib = st_reg.upcount[11:8];
		end else if (r_idx == uio_pkg::IDX_CNT_HIGH) begin
			rd_nib = st_reg.upcount[15:12];
		end else if (r_idx == uio_pkg::IDX_TIMER_RST) begin
			rd_nib = uio_pkg::NIB_RESET;
		end else if (r_idx == uio_pkg::IDX_HEAVY_LOAD) begin
			rd_nib[uio_pkg::BIT_D3] = st_reg.heavy_load_select;
		end else if (r_idx == uio_pkg::IDX_LCD_DRIVE) begin
			rd_nib[uio_pkg::BIT_D3] = st_reg.lcd_static_dynamic;
		end else if (r_idx == uio_pkg::IDX_BIDIR_DIR) begin
			rd_nib[uio_pkg::BIT_D0] = st_reg.port_direction_bit;
		end else if (r_idx == uio_pkg::IDX_BUZ_DIVIDED_CLOCK_OUT) begin
			rd_nib[uio_pkg::BIT_D3] = st_reg.buzzer_tone_select;
			rd_nib[1:0] = st_reg.freq_out_sel;
		end else if (r_idx == uio_pkg::IDX_ADC_CLK) begin
			rd_nib[uio_pkg::BIT_D0] = st_reg.adc_clock_pick;
		end else if (r_idx == uio_pkg::IDX_IRQ_STATUS) begin
			rd_nib[uio_pkg::NUM_EV-1:0] = st_reg.irq_stat;
		end else if (r_idx == uio_pkg::IDX_IRQ_ENABLE) begin
			rd_nib[uio_pkg::NUM_EV-1:0] = st_reg.irq_en;
		end else if (r_idx == uio_pkg::IDX_IRQ_CLEAR) begin
			rd_nib = uio_pkg::NIB_RESET;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// a write lands only once both halves are held, so the bus may offer
	// address and data in either order at the cost of one extra cycle
	always_comb begin
		st_next = st_reg;
		ev = '0;
		st_next.timer_clear_cmd = 1'b0;
		// bus handshakes
		if (i_awvalid && o_awready) begin
			st_next.aw_full = 1'b1;
			st_next.aw_addr = i_awaddr;
		end
		if (i_wvalid && o_wready) begin
			st_next.w_full = 1'b1;
			st_next.w_nib = i_wdata[3:0];
			st_next.w_lane0 = i_wstrb[0];
		end
		if (st_reg.bvalid && i_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_reg.rvalid && i_rready) begin
			st_next.rvalid = 1'b0;
		end
		// up-counter runs on its tick; a nibble write overrides below
		if (i_count_tick) begin
			st_next.upcount = st_reg.upcount + uio_pkg::CNT_ONE;
			ev[uio_pkg::EV_CNT_WRAP] = (st_reg.upcount == uio_pkg::CNT_MAX);
		end
		// register write
		if (st_reg.aw_full && st_reg.w_full) begin
			st_next.aw_full = 1'b0;
			st_next.w_full = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = uio_pkg::RESP_OKAY;
			if (w_idx == uio_pkg::IDX_ADC_FLAG) begin
				st_next.bresp = uio_pkg::RESP_OKAY;
			end else if (w_idx == uio_pkg::IDX_ADC_CTRL) begin
				if (st_reg.w_lane0) begin
					st_next.adc_go = st_reg.w_nib[uio_pkg::BIT_D0];
					st_next.adc_channel_pick = st_reg.w_nib[uio_pkg::BIT_D3];
				end
			end else if (w_idx == uio_pkg::IDX_OUT_PORT) begin
				if (st_reg.w_lane0) begin
					st_next.out_data = st_reg.w_nib;
				end
			end else if (w_idx == uio_pkg::IDX_BIDIR_DATA) begin
				if (st_reg.w_lane0) begin
					st_next.bidir_latch = st_reg.w_nib;
				end
			end else if (w_idx == uio_pkg::IDX_CNT_LOW) begin
				if (st_reg.w_lane0) begin
					st_next.upcount[3:0] = st_reg.w_nib;
				end
			end else if (w_idx == uio_pkg::IDX_CNT_MIDLOW) begin
				if (st_reg.w_lane0) begin
					st_next.upcount[7:4] = st_reg.w_nib;
				end
			end else if (w_idx == uio_pkg::IDX_CNT_MIDHIGH) begin
				if (st_reg.w_lane0) begin
					st_next.upcount[11:8] = st_reg.w_nib;
				end
			end else if (w_idx == uio_pkg::IDX_CNT_HIGH) begin
				if (st_reg.w_lane0) begin
					st_next.upcount[15:12] = st_reg.w_nib;
				end
			end else if (w_idx == uio_pkg::IDX_TIMER_RST) begin
				st_next.timer_clear_cmd = st_reg.w_lane0 && st_reg.w_nib[uio_pkg::BIT_D0];
			end else if (w_idx == uio_pkg::IDX_HEAVY_LOAD) begin
				if (st_reg.w_lane0) begin
					st_next.heavy_load_select = st_reg.w_nib[uio_pkg::BIT_D3];
				end
			end else if (w_idx == uio_pkg::IDX_LCD_DRIVE) begin
				if (st_reg.w_lane0) begin
					st_next.lcd_static_dynamic = st_reg.w_nib[uio_pkg::BIT_D3];
				end
			end else if (w_idx == uio_pkg::IDX_BIDIR_DIR) begin
				if (st_reg.w_lane0) begin
					st_next.port_direction_bit = st_reg.w_nib[uio_pkg::BIT_D0];
				end
			end else if (w_idx == uio_pkg::IDX_BUZ_DIVIDED_CLOCK_OUT) begin
				if (st_reg.w_lane0) begin
					st_next.buzzer_tone_select = st_reg.w_nib[uio_pkg::BIT_D3];
					st_next.freq_out_sel = st_reg.w_nib[1:0];
				end
			end else if (w_idx == uio_pkg::IDX_ADC_CLK) begin
				if (st_reg.w_lane0) begin
					st_next.adc_clock_pick = st_reg.w_nib[uio_pkg::BIT_D0];
				end
			end else if (w_idx == uio_pkg::IDX_IRQ_STATUS) begin
				st_next.bresp = uio_pkg::RESP_OKAY;
			end else if (w_idx == uio_pkg::IDX_IRQ_ENABLE) begin
				if (st_reg.w_lane0) begin
					st_next.irq_en = st_reg.w_nib[uio_pkg::NUM_EV-1:0];
				end
			end else if (w_idx == uio_pkg::IDX_IRQ_CLEAR) begin
				if (st_reg.w_lane0) begin
					st_next.irq_stat = st_reg.irq_stat & ~st_reg.w_nib[uio_pkg::NUM_EV-1:0];
				end
			end else begin
				st_next.bresp = uio_pkg::RESP_SLVERR;
			end
		end
		// register read; the flag read clears it once the data is captured
		if (rd_take) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rd_nib;
			st_next.rresp = rd_hit ? uio_pkg::RESP_OKAY : uio_pkg::RESP_SLVERR;
			if (r_idx == uio_pkg::IDX_ADC_FLAG) begin
				st_next.adc_irq_flag = 1'b0;
			end
		end
		// events set last so a set beats a same-cycle clear
		if (i_adc_done) begin
			st_next.adc_irq_flag = 1'b1;
			ev[uio_pkg::EV_ADC] = 1'b1;
		end
		st_next.irq_stat = st_next.irq_stat | ev;
		// output pins, special functions on bits zero and one are gated by those data bits
		st_next.pins = st_reg.out_data;
		if (DIVIDED_CLOCK_OUT_USE) begin
			st_next.pins[uio_pkg::BIT_D0] = st_reg.out_data[uio_pkg::BIT_D0] && i_divided_clock_out_src[st_reg.freq_out_sel];
		end
		if (BUZZER_USE) begin
			st_next.pins[uio_pkg::BIT_D1] = st_reg.out_data[uio_pkg::BIT_D1] && tone;
		end
	end

	// tone select: one picks the lower tone
	assign tone = st_reg.buzzer_tone_select ? i_buzz_2k : i_buzz_4k;

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	// port latch and counter carry no reset value, so they simply keep going
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_reg <= '0;
			st_reg.bidir_latch <= st_next.bidir_latch;
			st_reg.upcount <= st_next.upcount;
		end else begin
			st_reg <= st_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign o_awready = !st_reg.aw_full && !st_reg.bvalid;
	assign o_wready = !st_reg.w_full && !st_reg.bvalid;
	assign o_bvalid = st_reg.bvalid;
	assign o_bresp = st_reg.bresp;
	assign o_arready = !st_reg.rvalid;
	assign o_rvalid = st_reg.rvalid;
	assign o_rresp = st_reg.rresp;
	assign o_rdata = {28'h0000000, st_reg.rdata};
	assign o_bidir_out = st_reg.bidir_latch;
	assign o_bidir_oe_n = {4{!st_reg.port_direction_bit}};
	assign o_out_pins = st_reg.pins;
	assign o_adc_go = st_reg.adc_go;
	assign o_adc_channel = st_reg.adc_channel_pick;
	assign o_adc_fast_clk = st_reg.adc_clock_pick;
	assign o_timer_clear = st_reg.timer_clear_cmd;
	assign o_heavy_load = st_reg.heavy_load_select;
	assign o_lcd_static = st_reg.lcd_static_dynamic;
	assign o_irq = |(st_reg.irq_stat & st_reg.irq_en);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	flag_read_clear_a: assert property (
		(rd_take && r_idx == uio_pkg::IDX_ADC_FLAG && !i_adc_done) |=> !st_reg.adc_irq_flag
	) else $error("flag not cleared by read");

	flag_set_wins_a: assert property (
		i_adc_done |=> st_reg.adc_irq_flag && st_reg.irq_stat[uio_pkg::EV_ADC]
	) else $error("a/d event lost");

	rdata_upper_zero_a: assert property (
		(rd_take && (r_idx == uio_pkg::IDX_ADC_FLAG || r_idx == uio_pkg::IDX_TIMER_RST)) |=> o_rdata[31:1] == 31'h0
	) else $error("unused read bits not zero");

	plain_pin_follow_a: assert property (
		##1 o_out_pins[3:2] == $past(st_reg.out_data[3:2])
	) else $error("output pin does not follow data");

	buzzer_gate_a: assert property (
		!st_reg.out_data[uio_pkg::BIT_D1] |=> !o_out_pins[uio_pkg::BIT_D1] || !BUZZER_USE
	) else $error("buzzer active while off");

	divided_clock_out_gate_a: assert property (
		!st_reg.out_data[uio_pkg::BIT_D0] |=> !o_out_pins[uio_pkg::BIT_D0] || !DIVIDED_CLOCK_OUT_USE
	) else $error("divided clock active while off");

	dir_drive_a: assert property (
		(st_reg.aw_full && st_reg.w_full && w_idx == uio_pkg::IDX_BIDIR_DIR && st_reg.w_lane0)
			|=> o_bidir_oe_n == {4{!$past(st_reg.w_nib[uio_pkg::BIT_D0])}}
	) else $error("direction and drive disagree");

	timer_pulse_a: assert property (
		o_timer_clear |=> !o_timer_clear
	) else $error("timer clear longer than one cycle");

	write_answer_a: assert property (
		(st_reg.aw_full && st_reg.w_full && w_idx == uio_pkg::IDX_ADC_CTRL && st_reg.w_lane0)
			|=> o_bvalid && o_adc_go == $past(st_reg.w_nib[uio_pkg::BIT_D0])
	) else $error("a/d control write not applied");

	clk_sel_a: assert property (
		(st_reg.aw_full && st_reg.w_full && w_idx == uio_pkg::IDX_ADC_CLK && st_reg.w_lane0)
			|=> o_adc_fast_clk == $past(st_reg.w_nib[uio_pkg::BIT_D0])
	) else $error("a/d clock select not applied");

	count_step_a: assert property (
		(i_count_tick && !(st_reg.aw_full && st_reg.w_full)) |=> st_reg.upcount == $past(st_reg.upcount) + uio_pkg::CNT_ONE
	) else $error("up-counter did not step");

	heavy_read_a: assert property (
		(rd_take && r_idx == uio_pkg::IDX_HEAVY_LOAD) |=> o_rdata[3] == o_heavy_load && o_rdata[2:0] == 3'h0
	) else $error("heavy load readback wrong");

	cov_flag_read: cover property (st_reg.adc_irq_flag ##1 rd_take && r_idx == uio_pkg::IDX_ADC_FLAG);
	cov_irq: cover property (o_irq);
	cov_wrap: cover property (ev[uio_pkg::EV_CNT_WRAP]);
	cov_port_out: cover property (st_reg.port_direction_bit && o_bidir_oe_n == 4'h0);
endmodule

// >>> inc/uio_pkg.sv
/*
 * constants for the upper i/o register bank: register indices, byte address
 * scaling, field positions, reset values and bus response codes.
 * assumes: shared by the bank and its bench, nothing imported.
 */
package uio_pkg;
	// ---------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [9:0] IDX_ADC_FLAG = 10'h0f0;
	localparam logic [9:0] IDX_ADC_CTRL = 10'h0f1;
	localparam logic [9:0] IDX_OUT_PORT = 10'h0f3;
	localparam logic [9:0] IDX_BIDIR_DATA = 10'h0f4;
	localparam logic [9:0] IDX_CNT_LOW = 10'h0f5;
	localparam logic [9:0] IDX_CNT_MIDLOW = 10'h0f6;
	localparam logic [9:0] IDX_CNT_MIDHIGH = 10'h0f7;
	localparam logic [9:0] IDX_CNT_HIGH = 10'h0f8;
	localparam logic [9:0] IDX_TIMER_RST = 10'h0f9;
	localparam logic [9:0] IDX_HEAVY_LOAD = 10'h0fa;
	localparam logic [9:0] IDX_LCD_DRIVE = 10'h0fb;
	localparam logic [9:0] IDX_BIDIR_DIR = 10'h0fc;
	localparam logic [9:0] IDX_BUZ_DIVIDED_CLOCK_OUT = 10'h0fd;
	localparam logic [9:0] IDX_ADC_CLK = 10'h0fe;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h100;
	localparam logic [9:0] IDX_IRQ_ENABLE = 10'h101;
	localparam logic [9:0] IDX_IRQ_CLEAR = 10'h102;
	localparam int ADDR_LSB = 2;
	// ---------------------------------------------------------------
	// field positions inside a nibble
	// ---------------------------------------------------------------
	localparam int BIT_D0 = 0;
	localparam int BIT_D1 = 1;
	localparam int BIT_D3 = 3;
	localparam int EV_ADC = 0;
	localparam int EV_CNT_WRAP = 1;
	localparam int NUM_EV = 2;
	// ---------------------------------------------------------------
	// reset values and bus answers
	// ---------------------------------------------------------------
	localparam logic [3:0] NIB_RESET = 4'h0;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> src/uio_sync.sv
/*
 * three-stage synchroniser for pin levels: the output moves only once the
 * second and third stages agree.
 * assumes: input is asynchronous to i_sys_clk; synchronous active-high reset.
 */
module uio_sync #(
	parameter int WIDTH = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_level
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] lvl;
	} uio_sync_t;
	uio_sync_t st_reg;
	uio_sync_t st_next;

	// ---------------------------------------------------------------
	// stages
	// ---------------------------------------------------------------
	// first stage is read only by the second
	always_comb begin
		st_next = st_reg;
		st_next.s1 = i_async;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.lvl[i] = st_reg.s3[i];
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_level = st_reg.lvl;
endmodule

// >>> sim/uio_bank_tb_top.sv
/*
 * self-checking bench for the upper i/o register bank: axi4-lite master tasks,
 * pin stimulus, and a monitor that checks each bus answer against a queue of notes.
 * assumes: uio_pkg is compiled first; one 50 mhz clock; the bench drives every bank input.
 */
`define CHK(nm, exp, got) chk(nm, 32'(exp), 32'(got))
module uio_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [31:0] data; logic [1:0] resp;} uio_exp_t;
	localparam logic [1:0] RSP_OK = uio_pkg::RESP_OKAY;
	localparam logic [1:0] RSP_ERR = uio_pkg::RESP_SLVERR;
	logic sys_clk, rst, awvalid, wvalid, bready, arvalid, rready, adc_done, count_tick, buzz_2k, buzz_4k;
	logic awready, wready, bvalid, arready, rvalid, adc_go, adc_channel, adc_fast_clk, timer_clear;
	logic heavy_load, lcd_static, irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, freq_src, bidir_in, bidir_out, bidir_oe_n, out_pins, v;
	logic [1:0] bresp, rresp, sel;
	logic [15:0] c;
	int n_mismatch, cmp_count, tclr_seen, tclr_exp, seed;
	uio_exp_t rq[$];
	logic [1:0] bq[$];
	logic [9:0] t_idx [9] = '{uio_pkg::IDX_ADC_FLAG, uio_pkg::IDX_ADC_CTRL, uio_pkg::IDX_OUT_PORT,
		uio_pkg::IDX_TIMER_RST, uio_pkg::IDX_HEAVY_LOAD, uio_pkg::IDX_LCD_DRIVE, uio_pkg::IDX_BIDIR_DIR,
		uio_pkg::IDX_BUZ_DIVIDED_CLOCK_OUT, uio_pkg::IDX_ADC_CLK};
	logic [3:0] t_mask [9] = '{4'h0, 4'h9, 4'hf, 4'h0, 4'h8, 4'h8, 4'h1, 4'hb, 4'h1};

	uio_bank DUT (.i_sys_clk(sys_clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.i_adc_done(adc_done), .i_count_tick(count_tick), .i_divided_clock_out_src(freq_src), .i_buzz_2k(buzz_2k),
		.i_buzz_4k(buzz_4k), .i_bidir_in(bidir_in), .o_bidir_out(bidir_out), .o_bidir_oe_n(bidir_oe_n),
		.o_out_pins(out_pins), .o_adc_go(adc_go), .o_adc_channel(adc_channel),
		.o_adc_fast_clk(adc_fast_clk), .o_timer_clear(timer_clear), .o_heavy_load(heavy_load),
		.o_lcd_static(lcd_static), .o_irq(irq));

	// ---------------------------------------------------------------
	// clock, watchdog and verdict
	// ---------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// the whole sequence needs a few hundred cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		summarize();
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// one statement per compare, so a check may stand alone in a case item
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// ---------------------------------------------------------------
	// response monitor
	// ---------------------------------------------------------------
	// sampled at the falling edge: settled values just ahead of the handshake edge
	always @(negedge sys_clk) begin
		uio_exp_t e;
		if (rvalid && rready) begin
			e = rq.pop_front();
			`CHK("rdata", e.data, rdata);
			`CHK("rresp", e.resp, rresp);
		end
		if (bvalid && bready) begin
			`CHK("bresp", bq.pop_front(), bresp);
		end
		if (timer_clear) tclr_seen++;
	end

	// ---------------------------------------------------------------
	// bus master tasks
	// ---------------------------------------------------------------
	// handshakes are judged at the falling edge so no race with the slave's own updates
	task automatic wr(input logic [9:0] idx, input logic [3:0] d, input logic [1:0] er);
		logic a_hs, w_hs, a_d, w_d, b_hs;
		@(posedge sys_clk);
		awaddr <= {idx, 2'b00};
		wdata <= {28'h0000000, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bq.push_back(er);
		a_d = 1'b0;
		w_d = 1'b0;
		do begin
			@(negedge sys_clk);
			a_hs = !a_d && awready;
			w_hs = !w_d && wready;
			@(posedge sys_clk);
			if (a_hs) begin
				awvalid <= 1'b0;
				a_d = 1'b1;
			end
			if (w_hs) begin
				wvalid <= 1'b0;
				w_d = 1'b1;
			end
		end while (!(a_d && w_d));
		do begin
			@(negedge sys_clk);
			b_hs = bvalid;
			@(posedge sys_clk);
		end while (!b_hs);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] idx, input logic [3:0] d, input logic [1:0] er);
		logic h;
		uio_exp_t e;
		@(posedge sys_clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		e.data = {28'h0000000, d};
		e.resp = er;
		rq.push_back(e);
		do begin
			@(negedge sys_clk);
			h = arready;
			@(posedge sys_clk);
		end while (!h);
		arvalid <= 1'b0;
		do begin
			@(negedge sys_clk);
			h = rvalid;
			@(posedge sys_clk);
		end while (!h);
		rready <= 1'b0;
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
		{adc_done, count_tick, buzz_2k, buzz_4k, freq_src, bidir_in} = '0;
		seed = 32'h384a6a71;
		rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		settle(1);
		`CHK("bidir_oe_n", 4'hf, bidir_oe_n);
		`CHK("out_pins", 4'h0, out_pins);
		`CHK("adc_fast_clk", 1'b0, adc_fast_clk);
		`CHK("heavy_load", 1'b0, heavy_load);
		foreach (t_idx[i]) rd(t_idx[i], 4'h0, RSP_OK);
		// random write and read back over the control table; tone sources idle so pins 3:2 show data and pins 1:0 stay low
		repeat (2) foreach (t_idx[i]) begin
			v = 4'($random(seed));
			wr(t_idx[i], v, RSP_OK);
			if (t_idx[i] == uio_pkg::IDX_TIMER_RST && v[0]) tclr_exp++;
			rd(t_idx[i], v & t_mask[i], RSP_OK);
			settle(1);
			case (t_idx[i])
				uio_pkg::IDX_ADC_CTRL: begin
					`CHK("adc_go", v[0], adc_go);
					`CHK("adc_channel", v[3], adc_channel);
				end
				uio_pkg::IDX_OUT_PORT: `CHK("out_pins", {v[3:2], 2'b00}, out_pins);
				uio_pkg::IDX_HEAVY_LOAD: `CHK("heavy_load", v[3], heavy_load);
				uio_pkg::IDX_LCD_DRIVE: `CHK("lcd_static", v[3], lcd_static);
				uio_pkg::IDX_ADC_CLK: `CHK("adc_fast_clk", v[0], adc_fast_clk);
				default: ;
			endcase
		end
		wr(uio_pkg::IDX_TIMER_RST, 4'h1, RSP_OK);
		tclr_exp++;
		// a/d event: flag, read clear, masked and enabled interrupt, w1c clear
		wr(uio_pkg::IDX_IRQ_ENABLE, 4'h0, RSP_OK);
		@(posedge sys_clk);
		adc_done <= 1'b1;
		@(posedge sys_clk);
		adc_done <= 1'b0;
		settle(2);
		`CHK("irq", 1'b0, irq);
		rd(uio_pkg::IDX_IRQ_STATUS, 4'h1, RSP_OK);
		wr(uio_pkg::IDX_IRQ_ENABLE, 4'h3, RSP_OK);
		settle(1);
		`CHK("irq", 1'b1, irq);
		rd(uio_pkg::IDX_ADC_FLAG, 4'h1, RSP_OK);
		rd(uio_pkg::IDX_ADC_FLAG, 4'h0, RSP_OK);
		wr(uio_pkg::IDX_IRQ_CLEAR, 4'h1, RSP_OK);
		settle(1);
		`CHK("irq", 1'b0, irq);
		rd(uio_pkg::IDX_IRQ_STATUS, 4'h0, RSP_OK);
		// counter nibbles, one tick, then a wrap from all ones
		for (int r = 0; r < 2; r++) begin
			c = r ? 16'hffff : 16'($random(seed));
			for (int k = 0; k < 4; k++) wr(uio_pkg::IDX_CNT_LOW + 10'(k), c[4*k+:4], RSP_OK);
			for (int k = 0; k < 4; k++) rd(uio_pkg::IDX_CNT_LOW + 10'(k), c[4*k+:4], RSP_OK);
			@(posedge sys_clk);
			count_tick <= 1'b1;
			@(posedge sys_clk);
			count_tick <= 1'b0;
			c = c + 16'h0001;
			for (int k = 0; k < 4; k++) rd(uio_pkg::IDX_CNT_LOW + 10'(k), c[4*k+:4], RSP_OK);
		end
		rd(uio_pkg::IDX_IRQ_STATUS, 4'h2, RSP_OK);
		settle(1);
		`CHK("irq", 1'b1, irq);
		wr(uio_pkg::IDX_IRQ_CLEAR, 4'h3, RSP_OK);
		// special outputs: every divided-clock pick, each with the tone choice set by the pick's low bit
		@(posedge sys_clk);
		freq_src <= 4'h6;
		buzz_2k <= 1'b1;
		buzz_4k <= 1'b0;
		wr(uio_pkg::IDX_OUT_PORT, 4'h3, RSP_OK);
		for (int s = 0; s < 4; s++) begin
			sel = 2'(s);
			wr(uio_pkg::IDX_BUZ_DIVIDED_CLOCK_OUT, {sel[0], 1'b0, sel}, RSP_OK);
			settle(2);
			`CHK("out_pins", {2'b00, sel[0], freq_src[sel]}, out_pins);
		end
		wr(uio_pkg::IDX_OUT_PORT, 4'h0, RSP_OK);
		settle(2);
		`CHK("out_pins", 4'h0, out_pins);
		// bidirectional port: latch driven as output, pin level read as input
		v = 4'($random(seed));
		wr(uio_pkg::IDX_BIDIR_DIR, 4'h1, RSP_OK);
		wr(uio_pkg::IDX_BIDIR_DATA, v, RSP_OK);
		settle(1);
		`CHK("bidir_oe_n", 4'h0, bidir_oe_n);
		`CHK("bidir_out", v, bidir_out);
		rd(uio_pkg::IDX_BIDIR_DATA, v, RSP_OK);
		@(posedge sys_clk);
		bidir_in <= ~v;
		wr(uio_pkg::IDX_BIDIR_DIR, 4'h0, RSP_OK);
		settle(4);
		`CHK("bidir_oe_n", 4'hf, bidir_oe_n);
		rd(uio_pkg::IDX_BIDIR_DATA, ~v, RSP_OK);
		// unmapped places answer with an error and zero data
		rd(10'h0ff, 4'h0, RSP_ERR);
		wr(10'h0ff, 4'hf, RSP_ERR);
		rd(10'h103, 4'h0, RSP_ERR);
		settle(2);
		`CHK("timer_clear pulses", tclr_exp, tclr_seen);
		summarize();
	end
endmodule
